// ==== inc/ccd_pkg.sv ====
// Package for the core clock divider with fast interrupt response.
// Assumes the divider's own clock is the PLL output clock.
package ccd_pkg;

	// ----------------------------------------------------------------
	// Clock source and divide settings
	// ----------------------------------------------------------------
	localparam int unsigned XTAL_HZ       = 32768;
	localparam int unsigned PLL_MULT      = 512;
	localparam int unsigned PLL_HZ        = XTAL_HZ * PLL_MULT;
	localparam int          DIV_SEL_W     = 3;
	localparam int          PRESCALE_W    = 7;
	localparam logic [2:0]  DIV_SEL_RESET = 3'h3;
	localparam logic [2:0]  DIV_SEL_FAST  = 3'h0;
	localparam int          NEST_W        = 2;
	localparam logic [1:0]  NEST_MAX      = 2'h3;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		CCD_NORMAL = 1'b0,
		CCD_FAST   = 1'b1
	} ccd_mode_t;

	// Interrupt sequencing events from the core, one-cycle pulses
	typedef struct packed {
		logic entry;
		logic ret;
	} ccd_irq_ev_t;

	// Software control bits
	typedef struct packed {
		logic       fast_irq_response;
		logic [2:0] core_divide_select;
	} ccd_ctrl_t;

endpackage

// ==== verilog/ccd_core_clock_divider.sv ====
// Core clock divider: derives a core clock enable from the PLL clock.
// Assumes CORE_CLK_IN is the PLL output and that interrupt entry and
// return pulses come from the core's sequencer, synchronous to it.
`timescale 1ns/1ps

// Notes on behaviour
// - With fast response set, the core runs undivided while servicing any interrupt.
// - On return from the last open interrupt the core goes back to the divide-select rate.
// - With fast response clear, interrupts run at the divide-select rate too.
// - Divide-select value n gives the PLL clock divided by two to the power n.
// - After reset the divide setting is 011, divide by eight.
// - The divider counts the PLL clock so all settings stay phase locked to it.
module ccd_core_clock_divider
	import ccd_pkg::*;
(
	// Clock and reset
	input  wire logic                 CORE_CLK_IN,
	input  wire logic                 RST_IN,
	// Software control
	input  wire ccd_ctrl_t            CTRL_IN,
	// Interrupt sequencing
	input  wire ccd_irq_ev_t          IRQ_EV_IN,
	// Core clock
	output logic                      CORE_CLK_EN_OUT,
	output logic [DIV_SEL_W-1:0]      ACTIVE_DIV_OUT,
	output logic                      FAST_MODE_OUT
);

	// ----------------------------------------------------------------
	// Control capture
	// ----------------------------------------------------------------
	logic [DIV_SEL_W-1:0] sel_q;
	logic                 fast_resp_q;

	// Both fields move together, one edge after software changes them
	// default divide by eight
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			sel_q       <= DIV_SEL_RESET;
			fast_resp_q <= 1'b0;
		end else begin
			sel_q       <= CTRL_IN.core_divide_select;
			fast_resp_q <= CTRL_IN.fast_irq_response;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt nesting
	// ----------------------------------------------------------------
	// Two priority levels may nest, so a depth count is kept
	logic [NEST_W-1:0] depth_q;

	// Entry and return in one cycle cancel and leave the depth alone
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			depth_q <= '0;
		end else begin
			case ({IRQ_EV_IN.entry, IRQ_EV_IN.ret})
				2'b10: begin
					if (depth_q != NEST_MAX) begin
						depth_q <= depth_q + 2'h1;
					end
				end
				2'b01: begin
					if (depth_q != 2'h0) begin
						depth_q <= depth_q - 2'h1;
					end
				end
				default: begin
					depth_q <= depth_q;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Mode state
	// ----------------------------------------------------------------
	ccd_mode_t mode_q;
	ccd_mode_t mode_d;

	// Boost follows the live depth; clearing the fast bit drops it at once
	// fast while servicing
	always_comb begin
		case (mode_q)
			CCD_NORMAL: begin
				mode_d = (fast_resp_q && depth_q != 2'h0) ? CCD_FAST : CCD_NORMAL;
			end
			CCD_FAST: begin
				mode_d = (fast_resp_q && depth_q != 2'h0) ? CCD_FAST : CCD_NORMAL;
			end
			default: begin
				mode_d = CCD_NORMAL;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			mode_q <= CCD_NORMAL;
		end else begin
			mode_q <= mode_d;
		end
	end

	// ----------------------------------------------------------------
	// Prescaler and enable
	// ----------------------------------------------------------------
	// One free-running count serves every setting, so a rate change
	// never slips phase against the PLL-derived modulator clocks.
	logic [PRESCALE_W-1:0] pre_q;
	logic [DIV_SEL_W-1:0]  eff_div;
	logic [PRESCALE_W-1:0] pre_mask;
	logic [PRESCALE_W-1:0] pre_next;

	assign eff_div  = (mode_d == CCD_FAST) ? DIV_SEL_FAST : sel_q;
	assign pre_next = pre_q + 7'h1;

	// mask of the low n bits
	for (genvar i = 0; i < PRESCALE_W; i++) begin : g_mask
		assign pre_mask[i] = (i < int'(eff_div));
	end

	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_next;
		end
	end

	// Registered so the core never sees a glitch on its enable
	// one enable per 2^n cycles
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			CORE_CLK_EN_OUT <= 1'b0;
			ACTIVE_DIV_OUT  <= DIV_SEL_RESET;
			FAST_MODE_OUT   <= 1'b0;
		end else begin
			CORE_CLK_EN_OUT <= ((pre_next & pre_mask) == 7'h00);
			ACTIVE_DIV_OUT  <= eff_div;
			FAST_MODE_OUT   <= (mode_d == CCD_FAST);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Boost armed and at least one interrupt open
	sequence in_service_s;
		fast_resp_q && depth_q != 2'h0;
	endsequence

	// Undivided: enable every cycle at exponent zero
	sequence undivided_s;
		FAST_MODE_OUT && CORE_CLK_EN_OUT && (ACTIVE_DIV_OUT == DIV_SEL_FAST);
	endsequence

	// Boost still shown with nothing left open
	sequence leaving_s;
		FAST_MODE_OUT && depth_q == 2'h0;
	endsequence

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	fast_in_irq_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (RST_IN)
		in_service_s |=> undivided_s)
		else $error("core not undivided during fast interrupt service");

	return_restore_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (RST_IN)
		leaving_s |-> ##1 (ACTIVE_DIV_OUT == $past(sel_q)))
		else $error("rate not restored after interrupt return");

	ret_drop_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (RST_IN)
		(depth_q == 2'h1 && IRQ_EV_IN.ret && !IRQ_EV_IN.entry)
		|=> ##1 !FAST_MODE_OUT)
		else $error("boost kept after the last interrupt return");

	pair_ignore_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (RST_IN)
		(IRQ_EV_IN.entry && IRQ_EV_IN.ret) |=> (depth_q == $past(depth_q)))
		else $error("nest depth moved on entry and return together");

	no_boost_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (RST_IN)
		!fast_resp_q |=> !FAST_MODE_OUT)
		else $error("fast mode entered with fast response clear");

	sel_follow_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (RST_IN)
		!fast_resp_q |=> (ACTIVE_DIV_OUT == $past(sel_q)))
		else $error("divide setting ignored with fast response clear");

	div_period_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (RST_IN)
		(CORE_CLK_EN_OUT && ACTIVE_DIV_OUT == 3'h1 && $stable(ACTIVE_DIV_OUT))
		##1 (ACTIVE_DIV_OUT == 3'h1) |-> !CORE_CLK_EN_OUT)
		else $error("divide by two enable period wrong");

	reset_div_a: assert property (
		@(posedge CORE_CLK_IN)
		$fell(RST_IN) |-> ACTIVE_DIV_OUT == DIV_SEL_RESET)
		else $error("reset divide setting not divide by eight");

	reset_quiet_a: assert property (
		@(posedge CORE_CLK_IN)
		$fell(RST_IN) |-> (!FAST_MODE_OUT && !CORE_CLK_EN_OUT))
		else $error("fast mode or enable active straight after reset");

	// Every enable must sit on a boundary of the shared prescaler
	locked_phase_a: assert property (
		@(posedge CORE_CLK_IN) disable iff (RST_IN)
		!$past(RST_IN) |-> (CORE_CLK_EN_OUT ==
			((pre_q & ((7'h01 << ACTIVE_DIV_OUT) - 7'h01)) == 7'h00)))
		else $error("core enable off the shared prescaler boundary");

endmodule

// ==== sim/ccd_core_model.sv ====
// Model of the core's interrupt sequencer.
// Assumes one clock shared with the divider; requests come from the bench.
`timescale 1ns/1ps
module ccd_core_model
	import ccd_pkg::*;
(
	// Clock and reset
	input  wire logic  clk_in,
	input  wire logic  rst_in,
	// Requests from the bench
	input  wire logic  take_in,
	input  wire logic  leave_in,
	// Sequencer events
	output ccd_irq_ev_t ev_out
);
	logic [1:0] depth_q;
	logic       ret_ok;
	// No return without an open entry
	assign ret_ok = leave_in && (depth_q != 2'h0);
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ev_out  <= '0;
			depth_q <= 2'h0;
		end else begin
			ev_out.entry <= take_in;
			ev_out.ret   <= ret_ok;
			depth_q      <= depth_q + 2'(take_in) - 2'(ret_ok);
		end
	end
endmodule

// ==== sim/test_core_clock_divider_fast_irq.sv ====
// Testbench for the core clock divider.
// Assumes the sequencer model drives the interrupt events.
`timescale 1ns/1ps
module test_core_clock_divider_fast_irq;
	import ccd_pkg::*;
	logic        clk = 0, rst = 1, take = 0, leave = 0, en, fast;
	ccd_ctrl_t   ctrl = 4'h3;
	ccd_irq_ev_t ev;
	logic [2:0]  div, n;
	int          n_errors = 0, samples_checked = 0, cnt;
	// Reset, eight sweeps of 260, eight round trips and the nested case
	localparam int RUN_CYCLES = 9 + 8 * 260 + 8 * 13 + 24;
	always #5 clk = ~clk;
	ccd_core_model u_core(.clk_in(clk), .rst_in(rst), .take_in(take),
		.leave_in(leave), .ev_out(ev));
	ccd_core_clock_divider dut(.CORE_CLK_IN(clk), .RST_IN(rst), .CTRL_IN(ctrl),
		.IRQ_EV_IN(ev), .CORE_CLK_EN_OUT(en), .ACTIVE_DIV_OUT(div),
		.FAST_MODE_OUT(fast));
	task chk(input string s, input logic [8:0] seen, input logic [8:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %0h seen %0h", s, exp, seen);
		end
	endtask
	function automatic logic [8:0] want_div(input logic boost, input logic [2:0] sel);
		return boost ? 9'(DIV_SEL_FAST) : 9'(sel);
	endfunction
	function automatic logic [8:0] want_enables(input int sel, input int span);
		return 9'(span >> sel);
	endfunction
	task conclude;
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// --------------------------------------------------------------
	// Interrupt round trip
	// --------------------------------------------------------------
	task irq(input logic f);
		ctrl <= {f, n};
		repeat (3) @(posedge clk);
		take <= 1;
		@(posedge clk) take <= 0;
		repeat (4) @(posedge clk);
		chk("fast", 9'(fast), 9'(f));
		chk("div", 9'(div), want_div(f, n));
		if (f) chk("en fast", 9'(en), 9'h1);
		leave <= 1;
		@(posedge clk) leave <= 0;
		repeat (4) @(posedge clk);
		chk("div back", 9'(div), want_div(1'b0, n));
		chk("fast off", 9'(fast), 9'h0);
		$display("test irq boost %0d sel %0d done", f, n);
	endtask
	// --------------------------------------------------------------
	// Nested service, then entry and return in one cycle
	// --------------------------------------------------------------
	task nest;
		ctrl <= {1'b1, n};
		repeat (3) @(posedge clk);
		repeat (2) begin
			take <= 1;
			@(posedge clk) take <= 0;
			@(posedge clk);
		end
		leave <= 1;
		@(posedge clk) leave <= 0;
		repeat (4) @(posedge clk);
		chk("nest fast", 9'(fast), 9'h1);
		take <= 1;
		leave <= 1;
		@(posedge clk) take <= 0;
		leave <= 0;
		repeat (4) @(posedge clk);
		chk("pair fast", 9'(fast), 9'h1);
		chk("pair div", 9'(div), want_div(1'b1, n));
		leave <= 1;
		@(posedge clk) leave <= 0;
		repeat (4) @(posedge clk);
		chk("nest div back", 9'(div), want_div(1'b0, n));
		chk("nest fast off", 9'(fast), 9'h0);
		$display("test nested irq sel %0d done", n);
	endtask
	initial begin
		repeat (2 * RUN_CYCLES) @(posedge clk);
		n_errors++;
		conclude();
	end
	initial begin
		void'($urandom(42183));
		repeat (8) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		chk("reset div", 9'(div), 9'(DIV_SEL_RESET));
		// Sweep every setting, edge count over 256 cycles
		for (int i = 0; i < 8; i++) begin
			n = 3'(i);
			ctrl <= {1'b0, n};
			repeat (4) @(posedge clk);
			cnt = 0;
			repeat (256) @(posedge clk) cnt += int'(en);
			chk("enables", 9'(cnt), want_enables(i, 256));
			$display("test divide %0d done", i);
		end
		repeat (4) begin
			n = 3'($urandom_range(7, 1));
			irq(1'b1);
			irq(1'b0);
		end
		n = 3'($urandom_range(7, 1));
		nest();
		conclude();
	end
endmodule
